// [core/uoc_defs.svh]
// register map, field positions, reset values and timing counts
`ifndef UOC_DEFS_SVH
`define UOC_DEFS_SVH
`define UOC_ADR_CTRL 8'h00
`define UOC_ADR_TTL 8'h04
`define UOC_ADR_PEER_EN 8'h08
`define UOC_ADR_STATUS 8'h0C
`define UOC_ADR_RESOLVED 8'h10
`define UOC_ADR_CNT_BASE 8'h20
`define UOC_ADR_HWADDR_BASE 8'h40
`define UOC_CTRL_PCIE_FMT 0
`define UOC_CTRL_PREFILL_PKT 1
`define UOC_CTRL_LEVEL_LO 2
`define UOC_CTRL_VALIDATE 4
`define UOC_CTRL_RX_SIZE_HDR 5
`define UOC_CTRL_TRIG_ARP 6
`define UOC_CTRL_FLUSH_ARP 7
`define UOC_CTRL_CLEAR_CNT 8
`define UOC_CTRL_RESET 32'h0000_0000
`define UOC_TTL_RESET 8'h40
`define UOC_PEER_EN_RESET 4'h0
`define UOC_MAX_SIZE 16'h05C0
`define UOC_NUM_PEERS 4
`define UOC_TX_DEPTH 16
`define UOC_RX_DEPTH 16
`define UOC_CLK_MHZ 40
`define UOC_INIT_TIME_NS 2000
`define UOC_REC_TIME_NS 1000
`define UOC_INIT_CYC ((`UOC_INIT_TIME_NS * `UOC_CLK_MHZ + 999) / 1000)
`define UOC_REC_CYC ((`UOC_REC_TIME_NS * `UOC_CLK_MHZ + 999) / 1000)
`define UOC_EV_TX_NOTVLD 0
`define UOC_EV_TX_DONE 1
`define UOC_EV_TX_LEN 2
`define UOC_EV_RX_NOTVLD 3
`define UOC_EV_RX_DONE 4
`define UOC_EV_RX_CHKSUM 5
`define UOC_EV_RX_PACKET 6
`define UOC_EV_RX_MATCH 7
`endif

// [core/uoc_pkg.sv]
// types shared by the offload control and status block
package uoc_pkg;
  typedef struct packed {
    logic [2:0] peer;
    logic last;
    logic [3:0] keep;
    logic [31:0] data;
  } uoc_word_type;
  typedef struct packed {
    logic sop;
    logic last;
    logic [15:0] size;
    logic [3:0] keep;
    logic [31:0] data;
  } uoc_rx_word_type;
  typedef struct packed {
    logic tx_notvld_done;
    logic tx_done;
    logic tx_length_err;
    logic tx_size_err;
    logic tx_mismatch;
    logic tx_uflow;
    logic rx_notvld_done;
    logic rx_done;
    logic rx_packet_err;
    logic rx_chksum_err;
    logic rx_match_err;
    logic rx_oflow;
  } uoc_irq_type;
  typedef struct packed {
    logic arp_done;
    logic arp_sniff_done;
    logic pause;
    logic link_init_done;
    logic link_local_fault;
    logic link_remote_fault;
    logic link_recovering;
  } uoc_sts_type;
  typedef enum logic [2:0] {
    TX_IDLE, TX_HDR, TX_ARP, TX_FILL, TX_SEND, TX_DROP
  } uoc_tx_state_type;
endpackage

// [core/uoc_ctrl_status.sv]
// control, configuration and status logic of the udp offload engine
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "uoc_defs.svh"
module uoc_ctrl_status (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk,
  input wire logic link_local_fault_pin,
  input wire logic link_remote_fault_pin,
  input wire logic s_axis_tvalid,
  output logic s_axis_tready,
  input wire logic [31:0] s_axis_tdata,
  input wire logic [3:0] s_axis_tkeep,
  input wire logic s_axis_tlast,
  input wire logic [2:0] s_axis_tuser,
  output uoc_pkg::uoc_word_type tx_line_word,
  output logic tx_line_valid,
  output logic tx_line_crc_bad,
  output logic [7:0] tx_ttl,
  input wire logic rx_eng_valid,
  input wire uoc_pkg::uoc_rx_word_type rx_eng_word,
  input wire logic rx_eng_end,
  input wire logic rx_eng_is_udp,
  input wire logic rx_eng_crc_bad,
  input wire logic rx_eng_chksum_bad,
  input wire logic rx_eng_match_bad,
  output logic m_axis_tvalid,
  input wire logic m_axis_tready,
  output logic [31:0] m_axis_tdata,
  output logic [3:0] m_axis_tkeep,
  output logic m_axis_tlast,
  output logic arp_req,
  output logic [1:0] arp_req_peer,
  input wire logic arp_rsp_valid,
  input wire logic [1:0] arp_rsp_peer,
  input wire logic [47:0] arp_rsp_hw_addr,
  input wire logic sniff_done_evt,
  input wire logic pause_level,
  output uoc_pkg::uoc_irq_type irq,
  output uoc_pkg::uoc_sts_type sts
);
  import uoc_pkg::*;

  function automatic logic [2:0] keep_bytes(input logic [3:0] k);
    keep_bytes = {2'b00, k[0]} + {2'b00, k[1]}
                 + {2'b00, k[2]} + {2'b00, k[3]};
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---- wishbone slave and registers
  logic [31:0] ctrl_r;
  logic [7:0] ttl_r;
  logic [3:0] peer_en_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [31:0] cnt_r [8];
  logic [47:0] hw_addr_r [`UOC_NUM_PEERS];
  logic [3:0] resolved_r;
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr = bus_req & wb_we_i;
  wire [31:0] ctrl_nxt = merge(ctrl_r, wb_dat_i, wb_sel_i);
  wire cfg_pcie = ctrl_r[`UOC_CTRL_PCIE_FMT];
  wire cfg_prefill_pkt = ctrl_r[`UOC_CTRL_PREFILL_PKT];
  wire [1:0] cfg_level = ctrl_r[`UOC_CTRL_LEVEL_LO +: 2];
  wire cfg_validate = ctrl_r[`UOC_CTRL_VALIDATE];
  wire cfg_size_hdr = ctrl_r[`UOC_CTRL_RX_SIZE_HDR];
  wire cfg_trig_arp = ctrl_r[`UOC_CTRL_TRIG_ARP];
  wire cfg_flush = ctrl_r[`UOC_CTRL_FLUSH_ARP];
  wire cfg_clear = ctrl_r[`UOC_CTRL_CLEAR_CNT];
  wire adr_cnt = wb_adr_i[7:5] == 3'b001;
  wire adr_hw = wb_adr_i[7:4] == 4'h4;

  always_comb begin
    rdat_nxt = 32'h0000_0000;
    if (adr_cnt) begin
      rdat_nxt = cnt_r[wb_adr_i[4:2]];
    end else if (adr_hw) begin
      rdat_nxt = hw_addr_r[wb_adr_i[3:2]][31:0];
    end else begin
      case (wb_adr_i)
        `UOC_ADR_CTRL: rdat_nxt = ctrl_r;
        `UOC_ADR_TTL: rdat_nxt = {24'h00_0000, ttl_r};
        `UOC_ADR_PEER_EN: rdat_nxt = {28'h000_0000, peer_en_r};
        `UOC_ADR_STATUS: rdat_nxt = {25'h000_0000, sts};
        `UOC_ADR_RESOLVED: rdat_nxt = {28'h000_0000, resolved_r};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      ctrl_r <= `UOC_CTRL_RESET;
      ttl_r <= `UOC_TTL_RESET;
      peer_en_r <= `UOC_PEER_EN_RESET;
    end else begin
      ack_r <= bus_req;
      if (bus_req) begin
        rdat_r <= rdat_nxt;
      end
      if (bus_wr && wb_adr_i == `UOC_ADR_CTRL) begin
        ctrl_r <= {23'h00_0000, ctrl_nxt[8:0]};
      end
      if (bus_wr && wb_adr_i == `UOC_ADR_TTL && wb_sel_i[0]) begin
        ttl_r <= wb_dat_i[7:0];
      end
      if (bus_wr && wb_adr_i == `UOC_ADR_PEER_EN && wb_sel_i[0]) begin
        peer_en_r <= wb_dat_i[3:0];
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign tx_ttl = ttl_r;

  // ---- link clock and fault pins, two flops before use
  logic [2:0] lclk_s;
  logic [1:0] lf_s;
  logic [1:0] rf_s;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lclk_s <= 3'b000;
      lf_s <= 2'b00;
      rf_s <= 2'b00;
    end else begin
      lclk_s <= {lclk_s[1:0], link_clk};
      lf_s <= {lf_s[0], link_local_fault_pin};
      rf_s <= {rf_s[0], link_remote_fault_pin};
    end
  end
  // one tx line word per rising link clock edge models the line bandwidth
  wire line_tick = lclk_s[1] & ~lclk_s[2];

  // ---- link status
  logic [7:0] init_cnt_r;
  logic [7:0] rec_cnt_r;
  logic init_done_r;
  logic fault_d_r;
  wire fault_now = lf_s[1] | rf_s[1];
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      init_cnt_r <= 8'h00;
      init_done_r <= 1'b0;
      rec_cnt_r <= 8'h00;
      fault_d_r <= 1'b0;
    end else begin
      if (!init_done_r) begin
        init_cnt_r <= init_cnt_r + 8'h01;
        init_done_r <= init_cnt_r == 8'(`UOC_INIT_CYC - 1);
      end
      fault_d_r <= fault_now & init_done_r;
      if (fault_d_r && !fault_now) begin
        rec_cnt_r <= 8'(`UOC_REC_CYC);
      end else if (rec_cnt_r != 8'h00) begin
        rec_cnt_r <= rec_cnt_r - 8'h01;
      end
    end
  end

  // ---- tx fifo
  uoc_word_type tx_mem [`UOC_TX_DEPTH];
  logic [4:0] tx_wp_r;
  logic [4:0] tx_rp_r;
  logic [4:0] tx_lasts_r;
  wire [4:0] tx_cnt = tx_wp_r - tx_rp_r;
  wire tx_full = tx_cnt == 5'(`UOC_TX_DEPTH);
  wire tx_push = s_axis_tvalid & ~tx_full;
  uoc_word_type tx_head;
  assign tx_head = tx_mem[tx_rp_r[3:0]];
  logic tx_pop;
  assign s_axis_tready = ~tx_full;

  // ---- tx control
  uoc_tx_state_type tx_st_r;
  logic [15:0] tx_size_r;
  logic [15:0] tx_bytes_r;
  logic [2:0] tx_peer_r;
  logic tx_first_r;
  logic [3:0] want_r;
  wire [15:0] hdr_size = cfg_pcie ? {4'h0, tx_head.data[9:0], 2'b00}
                                  : tx_head.data[15:0];
  wire size_bad = hdr_size == 16'h0000 || hdr_size > `UOC_MAX_SIZE;
  wire peer_bad = tx_head.peer >= 3'(`UOC_NUM_PEERS)
                  || !peer_en_r[tx_head.peer[1:0]];
  wire [4:0] level_words = 5'h01 << cfg_level;
  wire tx_ready = cfg_prefill_pkt ? (tx_lasts_r != 5'h00 || tx_full)
                                  : tx_cnt >= level_words;
  wire tx_empty = tx_cnt == 5'h00;
  wire send_pop = tx_st_r == TX_SEND && line_tick && !tx_empty;
  wire [15:0] bytes_nxt = tx_bytes_r + {13'h0000, keep_bytes(tx_head.keep)};
  wire end_len_bad = bytes_nxt != tx_size_r;
  wire send_last = send_pop && tx_head.last;
  wire uflow = tx_st_r == TX_SEND && line_tick && tx_empty
               && !cfg_prefill_pkt;
  assign tx_pop = send_pop || (tx_st_r == TX_DROP && !tx_empty);

  always_ff @(posedge clk_sys) begin
    if (tx_push) begin
      tx_mem[tx_wp_r[3:0]] <= '{peer: s_axis_tuser, last: s_axis_tlast,
                                keep: s_axis_tkeep, data: s_axis_tdata};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_wp_r <= 5'h00;
      tx_rp_r <= 5'h00;
      tx_lasts_r <= 5'h00;
    end else begin
      tx_wp_r <= tx_wp_r + {4'h0, tx_push};
      tx_rp_r <= tx_rp_r + {4'h0, tx_pop};
      tx_lasts_r <= tx_lasts_r + {4'h0, tx_push & s_axis_tlast}
                    - {4'h0, tx_pop & tx_head.last};
    end
  end

  // the header word itself goes to the line; only later words are counted
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_st_r <= TX_IDLE;
      tx_size_r <= 16'h0000;
      tx_bytes_r <= 16'h0000;
      tx_peer_r <= 3'h0;
      tx_first_r <= 1'b0;
    end else begin
      case (tx_st_r)
        TX_IDLE: if (!tx_empty) begin
          tx_st_r <= TX_HDR;
        end
        TX_HDR: begin
          tx_size_r <= hdr_size;
          tx_peer_r <= tx_head.peer;
          tx_bytes_r <= 16'h0000;
          tx_first_r <= 1'b1;
          if (size_bad || peer_bad) begin
            tx_st_r <= TX_DROP;
          end else if (!resolved_r[tx_head.peer[1:0]]) begin
            tx_st_r <= TX_ARP;
          end else begin
            tx_st_r <= TX_FILL;
          end
        end
        TX_ARP: if (resolved_r[tx_peer_r[1:0]]) begin
          tx_st_r <= TX_FILL;
        end
        TX_FILL: if (tx_ready) begin
          tx_st_r <= TX_SEND;
        end
        TX_SEND: if (send_pop) begin
          tx_first_r <= 1'b0;
          if (!tx_first_r) begin
            tx_bytes_r <= bytes_nxt;
          end
          if (tx_head.last) begin
            tx_st_r <= TX_IDLE;
          end
        end
        TX_DROP: if (!tx_empty && tx_head.last) begin
          tx_st_r <= TX_IDLE;
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  wire hdr_only_last = tx_first_r && tx_size_r != 16'h0000;
  wire len_bad = send_last && (tx_first_r ? hdr_only_last : end_len_bad);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_line_word <= '0;
      tx_line_valid <= 1'b0;
      tx_line_crc_bad <= 1'b0;
    end else begin
      tx_line_valid <= send_pop;
      tx_line_crc_bad <= len_bad;
      if (send_pop) begin
        tx_line_word <= tx_head;
      end
    end
  end

  // ---- arp table
  logic [3:0] pend_r;
  logic sniff_r;
  wire [3:0] need = peer_en_r & ~resolved_r & ~pend_r
                    & (cfg_trig_arp ? 4'hF : want_r);
  wire [1:0] need_idx = need[0] ? 2'd0 : need[1] ? 2'd1
                        : need[2] ? 2'd2 : 2'd3;
  wire busy = tx_st_r != TX_IDLE || pend_r != 4'h0;
  wire flush_go = cfg_flush && !busy;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      resolved_r <= 4'h0;
      pend_r <= 4'h0;
      want_r <= 4'h0;
      sniff_r <= 1'b0;
      arp_req <= 1'b0;
      arp_req_peer <= 2'd0;
    end else begin
      arp_req <= need != 4'h0 && !flush_go;
      arp_req_peer <= need_idx;
      if (flush_go) begin
        resolved_r <= 4'h0;
        pend_r <= 4'h0;
        want_r <= 4'h0;
        sniff_r <= 1'b0;
      end else begin
        if (need != 4'h0) begin
          pend_r[need_idx] <= 1'b1;
        end
        if (tx_st_r == TX_ARP) begin
          want_r[tx_peer_r[1:0]] <= 1'b1;
        end
        if (arp_rsp_valid) begin
          resolved_r[arp_rsp_peer] <= 1'b1;
          pend_r[arp_rsp_peer] <= 1'b0;
          want_r[arp_rsp_peer] <= 1'b0;
        end
      end
      // a sniff event in the flush cycle is kept, the set wins
      if (sniff_done_evt) begin
        sniff_r <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (arp_rsp_valid) begin
      hw_addr_r[arp_rsp_peer] <= arp_rsp_hw_addr;
    end
  end

  // ---- rx buffer; uncommitted words vanish when validation fails
  uoc_rx_word_type rx_mem [`UOC_RX_DEPTH];
  logic [4:0] rx_wp_r;
  logic [4:0] rx_cp_r;
  logic [4:0] rx_rp_r;
  logic rx_lost_r;
  logic hdr_sent_r;
  wire rx_full = (rx_wp_r - rx_rp_r) == 5'(`UOC_RX_DEPTH);
  wire rx_wr = rx_eng_valid & ~rx_full;
  wire rx_oflow = rx_eng_valid & rx_full;
  wire [4:0] rx_wp_after = rx_wp_r + {4'h0, rx_wr};
  wire rx_good = rx_eng_is_udp & ~rx_eng_crc_bad & ~rx_eng_chksum_bad
                 & ~rx_eng_match_bad;
  wire keep_pkt = rx_good & ~rx_lost_r & ~rx_oflow;
  uoc_rx_word_type rx_head;
  assign rx_head = rx_mem[rx_rp_r[3:0]];
  wire rx_avail = rx_rp_r != rx_cp_r;
  wire rx_load = rx_avail & (~m_axis_tvalid | m_axis_tready);
  wire hdr_phase = rx_head.sop & cfg_size_hdr & ~hdr_sent_r;

  always_ff @(posedge clk_sys) begin
    if (rx_wr) begin
      rx_mem[rx_wp_r[3:0]] <= rx_eng_word;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_wp_r <= 5'h00;
      rx_cp_r <= 5'h00;
      rx_lost_r <= 1'b0;
    end else if (!cfg_validate) begin
      rx_wp_r <= rx_wp_after;
      rx_cp_r <= rx_wp_after;
      rx_lost_r <= 1'b0;
    end else if (rx_eng_end) begin
      rx_lost_r <= 1'b0;
      if (keep_pkt) begin
        rx_wp_r <= rx_wp_after;
        rx_cp_r <= rx_wp_after;
      end else begin
        rx_wp_r <= rx_cp_r;
      end
    end else begin
      rx_wp_r <= rx_wp_after;
      rx_lost_r <= rx_lost_r | rx_oflow;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_rp_r <= 5'h00;
      hdr_sent_r <= 1'b0;
      m_axis_tvalid <= 1'b0;
      m_axis_tdata <= 32'h0000_0000;
      m_axis_tkeep <= 4'h0;
      m_axis_tlast <= 1'b0;
    end else if (rx_load) begin
      m_axis_tvalid <= 1'b1;
      m_axis_tdata <= hdr_phase ? {16'h0000, rx_head.size} : rx_head.data;
      m_axis_tkeep <= hdr_phase ? 4'hF : rx_head.keep;
      m_axis_tlast <= hdr_phase ? 1'b0 : rx_head.last;
      hdr_sent_r <= hdr_phase;
      rx_rp_r <= rx_rp_r + {4'h0, ~hdr_phase};
    end else if (m_axis_tready) begin
      m_axis_tvalid <= 1'b0;
    end
  end

  // ---- event pulses and statistics
  logic [7:0] ev;
  assign ev[`UOC_EV_TX_NOTVLD] = arp_req;
  assign ev[`UOC_EV_TX_DONE] = send_last & ~len_bad;
  assign ev[`UOC_EV_TX_LEN] = len_bad;
  assign ev[`UOC_EV_RX_NOTVLD] = rx_eng_end & ~rx_eng_is_udp;
  assign ev[`UOC_EV_RX_DONE] = rx_eng_end & rx_good;
  assign ev[`UOC_EV_RX_CHKSUM] = rx_eng_end & rx_eng_chksum_bad;
  assign ev[`UOC_EV_RX_PACKET] = rx_eng_end & rx_eng_crc_bad;
  assign ev[`UOC_EV_RX_MATCH] = rx_eng_end & rx_eng_match_bad;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      irq <= '0;
    end else begin
      irq.tx_notvld_done <= ev[`UOC_EV_TX_NOTVLD];
      irq.tx_done <= ev[`UOC_EV_TX_DONE];
      irq.tx_length_err <= ev[`UOC_EV_TX_LEN];
      irq.tx_size_err <= tx_st_r == TX_HDR && size_bad;
      irq.tx_mismatch <= tx_st_r == TX_HDR && !size_bad && peer_bad;
      irq.tx_uflow <= uflow;
      irq.rx_notvld_done <= ev[`UOC_EV_RX_NOTVLD];
      irq.rx_done <= ev[`UOC_EV_RX_DONE];
      irq.rx_packet_err <= ev[`UOC_EV_RX_PACKET];
      irq.rx_chksum_err <= ev[`UOC_EV_RX_CHKSUM];
      irq.rx_match_err <= ev[`UOC_EV_RX_MATCH];
      irq.rx_oflow <= rx_oflow;
    end
  end

  // counters see the same cycle as the pulse source, on the same edge as irq
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cnt
      always_ff @(posedge clk_sys) begin
        if (!rst_b || cfg_clear) begin
          cnt_r[gi] <= 32'h0000_0000;
        end else if (ev[gi]) begin
          cnt_r[gi] <= cnt_r[gi] + 32'h0000_0001;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sts <= '0;
    end else begin
      sts.arp_done <= peer_en_r != 4'h0
                      && (resolved_r & peer_en_r) == peer_en_r;
      sts.arp_sniff_done <= sniff_r;
      sts.pause <= pause_level;
      sts.link_init_done <= init_done_r;
      sts.link_local_fault <= init_done_r & lf_s[1];
      sts.link_remote_fault <= init_done_r & rf_s[1];
      sts.link_recovering <= rec_cnt_r != 8'h00;
    end
  end
endmodule // uoc_ctrl_status

// [test/uoc_ctrl_status_properties.sv]
// port checks for the offload control and status block
`timescale 1ns/1ps
module uoc_cs_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_ack_o,
  input wire logic tx_line_valid,
  input wire uoc_pkg::uoc_word_type tx_line_word,
  input wire logic tx_line_crc_bad,
  input wire uoc_pkg::uoc_irq_type irq,
  input wire uoc_pkg::uoc_sts_type sts
);
  import uoc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_done_pulse: assert property (irq.tx_done |=> !irq.tx_done)
    else $error("tx done not single");
  a_len_pulse: assert property (
    irq.tx_length_err |=> !irq.tx_length_err)
    else $error("length error not single");
  a_crc_on_last: assert property (
    tx_line_crc_bad |-> tx_line_valid && tx_line_word.last)
    else $error("crc corrupt off last word");
  a_size_pulse: assert property (irq.tx_size_err |=> !irq.tx_size_err)
    else $error("size error not single");
  a_mis_pulse: assert property (irq.tx_mismatch |=> !irq.tx_mismatch)
    else $error("mismatch not single");
  a_rx_distinct: assert property (
    irq.rx_done |-> !irq.rx_notvld_done && !irq.rx_packet_err)
    else $error("rx done with other end");
  a_chk_pulse: assert property (
    irq.rx_chksum_err |=> !irq.rx_chksum_err)
    else $error("checksum error not single");
  a_fault_gated: assert property (
    !sts.link_init_done |-> !sts.link_local_fault
    && !sts.link_remote_fault)
    else $error("fault shown while initialising");
  a_init_low: assert property (
    $rose(rst_b) |-> !sts.link_init_done [*8])
    else $error("init done too early");
endmodule // uoc_cs_props
bind uoc_ctrl_status uoc_cs_props u_uoc_cs_props (.clk_sys, .rst_b,
  .wb_ack_o, .tx_line_valid, .tx_line_word, .tx_line_crc_bad, .irq, .sts);

// [test/uoc_far_model.sv]
// far side: link clock source and address resolver
`timescale 1ns/1ps
module uoc_far_model (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic arp_req,
  input wire logic [1:0] arp_req_peer,
  output logic link_clk,
  output logic arp_rsp_valid,
  output logic [1:0] arp_rsp_peer,
  output logic [47:0] arp_rsp_hw_addr
);
  logic [3:0] dly_r = '0;
  logic [47:0] addr_r = '0;
  initial link_clk = '0;
  initial arp_rsp_peer = '0;
  // link clock stands still outside frames
  always #100 if (run) link_clk = ~link_clk;
  assign arp_rsp_valid = dly_r[3];
  // address only means something with its valid pulse
  assign arp_rsp_hw_addr = arp_rsp_valid ? addr_r : ~addr_r;
  always @(posedge clk_sys) begin
    dly_r <= {dly_r[2:0], arp_req};
    if (arp_req) begin
      arp_rsp_peer <= arp_req_peer;
      addr_r <= {46'h0, arp_req_peer} + 48'h0A00_0000_0001;
    end
  end
endmodule // uoc_far_model

// [test/uoc_ctrl_status_tb.sv]
// self-checking bench for the offload control and status block
`timescale 1ns/1ps
`include "uoc_defs.svh"
module uoc_ctrl_status_tb;
  import uoc_pkg::*;
  typedef struct {logic [15:0] ct, sz; logic [2:0] pr; int nw;
    logic [3:0] fl; logic [13:0] care, exp;} uoc_row_type;
  logic clk_sys = '0, rst_b = '0, clr = 1'h1, run = '0;
  logic wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, wb_ack_o;
  logic [7:0] wb_adr_i = '0, tx_ttl;
  logic [31:0] wb_dat_i = '0, wb_dat_o, s_axis_tdata = '0, m_axis_tdata;
  logic [31:0] rd, m_d, m_h, last_d;
  logic link_local_fault_pin = '0, link_remote_fault_pin = '0, link_clk;
  logic s_axis_tvalid = '0, s_axis_tlast = '0, s_axis_tready;
  logic [2:0] s_axis_tuser = '0;
  uoc_rx_word_type rx_eng_word = '0;
  logic rx_eng_valid = '0, rx_eng_end = '0, rx_eng_is_udp = '0;
  logic rx_eng_crc_bad = '0, rx_eng_chksum_bad = '0, rx_eng_match_bad = '0;
  logic tx_line_valid, tx_line_crc_bad, m_axis_tvalid, m_axis_tlast;
  logic arp_req, arp_rsp_valid;
  logic [1:0] arp_req_peer, arp_rsp_peer;
  logic [47:0] arp_rsp_hw_addr;
  logic [3:0] m_axis_tkeep;
  logic [13:0] seen;
  uoc_word_type tx_line_word;
  uoc_irq_type irq;
  uoc_sts_type sts;
  int fails = 0, n_checks = 0;
  uoc_row_type rows[15];
  uoc_ctrl_status u_uoc_ctrl_status (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .link_clk, .link_local_fault_pin, .link_remote_fault_pin, .s_axis_tvalid,
    .s_axis_tready, .s_axis_tdata, .s_axis_tkeep(4'hF), .s_axis_tlast,
    .s_axis_tuser, .tx_line_word, .tx_line_valid, .tx_line_crc_bad, .tx_ttl,
    .rx_eng_valid, .rx_eng_word, .rx_eng_end, .rx_eng_is_udp, .rx_eng_crc_bad,
    .rx_eng_chksum_bad, .rx_eng_match_bad, .m_axis_tvalid,
    .m_axis_tready(1'h1), .m_axis_tdata, .m_axis_tkeep, .m_axis_tlast,
    .arp_req, .arp_req_peer, .arp_rsp_valid, .arp_rsp_peer, .arp_rsp_hw_addr,
    .sniff_done_evt(1'h0), .pause_level(1'h0), .irq, .sts);
  uoc_far_model u_uoc_far_model (.clk_sys, .run, .arp_req, .arp_req_peer,
    .link_clk, .arp_rsp_valid, .arp_rsp_peer, .arp_rsp_hw_addr);
  always #12.5 clk_sys = ~clk_sys;
  // pulses are caught sticky so a check never hangs on one exact cycle
  always @(posedge clk_sys) begin
    seen <= clr ? '0 : seen | {arp_req, tx_line_crc_bad, irq};
    if (tx_line_valid && tx_line_word.last) last_d <= tx_line_word.data;
    if (m_axis_tvalid) m_d <= m_axis_tdata;
    if (m_axis_tvalid && !m_axis_tlast) m_h <= m_axis_tdata;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= '0;
    wb_stb_i <= '0;
    @(posedge clk_sys);
  endtask
  task push(input logic [31:0] d, input logic l, input logic [2:0] u);
    s_axis_tvalid <= 1'h1;
    s_axis_tdata <= d;
    s_axis_tlast <= l;
    s_axis_tuser <= u;
    do @(posedge clk_sys); while (s_axis_tready !== 1'h1);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    end_of_test;
  end
  initial begin
    rows = '{
      '{16'h0000, 16'h0008, 3'h0, 2, 4'h0, 14'h3780, 14'h2400},
      '{16'h0001, 16'h0002, 3'h0, 2, 4'h0, 14'h3780, 14'h0400},
      '{16'h0002, 16'h000C, 3'h0, 3, 4'h0, 14'h3780, 14'h0400},
      '{16'h000C, 16'h0020, 3'h0, 8, 4'h0, 14'h3780, 14'h0400},
      '{16'h0000, 16'h0008, 3'h0, 1, 4'h0, 14'h3780, 14'h1200},
      '{16'h0000, 16'h0000, 3'h0, 0, 4'h0, 14'h0780, 14'h0100},
      '{16'h0000, 16'h05C1, 3'h0, 0, 4'h0, 14'h0780, 14'h0100},
      '{16'h0000, 16'h0004, 3'h3, 1, 4'h0, 14'h0780, 14'h0080},
      '{16'h0000, 16'h0004, 3'h4, 1, 4'h0, 14'h0780, 14'h0080},
      '{16'h0020, 16'h0000, 3'h0, 0, 4'h8, 14'h003E, 14'h0010},
      '{16'h0010, 16'h0000, 3'h0, 0, 4'h8, 14'h003E, 14'h0010},
      '{16'h0000, 16'h0000, 3'h0, 0, 4'hC, 14'h000E, 14'h0008},
      '{16'h0000, 16'h0000, 3'h0, 0, 4'hA, 14'h000E, 14'h0004},
      '{16'h0000, 16'h0000, 3'h0, 0, 4'h9, 14'h000E, 14'h0002},
      '{16'h0000, 16'h0000, 3'h0, 0, 4'h0, 14'h0030, 14'h0020}};
    // six cycles of reset keep the five slow-cycle minimum
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    clr <= '0;
    @(posedge clk_sys);
    chk("ttl", 32'h0000_0040, tx_ttl);
    repeat (70) @(posedge clk_sys);
    chk("init early", '0, sts.link_init_done);
    repeat (20) @(posedge clk_sys);
    chk("init", 32'h0000_0001, sts.link_init_done);
    wb(1'h0, 8'hFC, '0);
    chk("unmapped", '0, rd);
    wb(1'h1, `UOC_ADR_TTL, 32'h0000_0055);
    chk("ttl set", 32'h0000_0055, tx_ttl);
    wb(1'h1, `UOC_ADR_PEER_EN, 32'h0000_0001);
    foreach (rows[i]) begin
      wb(1'h1, `UOC_ADR_CTRL, {16'h0000, rows[i].ct});
      clr <= 1'h1;
      @(posedge clk_sys);
      clr <= '0;
      if (rows[i].care[5:0] !== '0) begin
        rx_eng_valid <= 1'h1;
        rx_eng_end <= 1'h1;
        rx_eng_word <= '{1'h1, 1'h1, 16'h0004, 4'hF, 32'hC0DE_0000 + i};
        {rx_eng_is_udp, rx_eng_crc_bad, rx_eng_chksum_bad,
          rx_eng_match_bad} <= rows[i].fl;
        @(posedge clk_sys);
        rx_eng_valid <= '0;
        rx_eng_end <= '0;
      end else begin
        run <= 1'h1;
        push({16'h0000, rows[i].sz}, rows[i].nw == 0, rows[i].pr);
        for (int w = 0; w < rows[i].nw; w++)
          push(32'hA5A5_0000 + w, w == rows[i].nw - 1, rows[i].pr);
        s_axis_tvalid <= '0;
      end
      // wait for every expected pulse, not just the first one
      repeat (3000)
        if ((seen & rows[i].exp) !== rows[i].exp) @(posedge clk_sys);
      repeat (8) @(posedge clk_sys);
      run <= '0;
      chk("events", rows[i].exp, seen & rows[i].care);
      if (rows[i].exp[10])
        chk("last", 32'hA5A5_0000 + rows[i].nw - 1, last_d);
      if (rows[i].exp[4])
        chk("rx data", 32'hC0DE_0000 + i, m_d);
      if (rows[i].ct[5])
        chk("rx hdr", 32'h0000_0004, m_h);
    end
    chk("arp done", 32'h0000_0001, sts.arp_done);
    wb(1'h0, `UOC_ADR_CNT_BASE + 8'h04, '0);
    chk("tx count", 32'h0000_0004, rd);
    wb(1'h0, `UOC_ADR_CNT_BASE + 8'h10, '0);
    chk("rx count", 32'h0000_0002, rd);
    wb(1'h1, `UOC_ADR_CTRL, 32'h0000_0100);
    wb(1'h0, `UOC_ADR_CNT_BASE + 8'h10, '0);
    chk("cleared", '0, rd);
    link_local_fault_pin <= 1'h1;
    link_remote_fault_pin <= 1'h1;
    repeat (8) @(posedge clk_sys);
    chk("local fault", 32'h0000_0001, sts.link_local_fault);
    chk("remote fault", 32'h0000_0001, sts.link_remote_fault);
    link_local_fault_pin <= '0;
    link_remote_fault_pin <= '0;
    repeat (8) @(posedge clk_sys);
    chk("recovering", 32'h0000_0001, sts.link_recovering);
    rst_b <= '0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    chk("init again", '0, sts.link_init_done);
    end_of_test;
  end
endmodule // uoc_ctrl_status_tb
